// File: fsps_pkg.sv
// Package of constants for the flash self-program sequencer
package fsps_pkg;
  localparam int          CLK_HZ           = 100_000_000;
  localparam int          ADDR_W           = 16;
  localparam int          WORD_BITS        = 6;
  localparam int          PAGE_WORDS       = 64;
  localparam int          ARM_WINDOW       = 4;
  localparam int          PROG_TIME_US_MIN = 3700;
  localparam int          PROG_TIME_US_MAX = 4500;
  localparam int          PROG_CYCLES      = (PROG_TIME_US_MIN * (CLK_HZ / 1_000_000) + 999) / 1000 * 1000 / 1000;
  localparam int          RC_DIV           = 100;
  localparam int          RC_TICKS_MIN     = (PROG_TIME_US_MIN + 0) ;
  localparam logic [15:0] APP_RESET_ADDR   = 16'h0000;
  localparam logic [15:0] BOOT_RESET_ADDR  = 16'h3800;
  localparam logic [15:0] RWW_LIMIT        = 16'h3800;
  localparam logic [7:0]  LOCK_RESET       = 8'hFF;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_POINTER      = 8'h04;
  localparam logic [7:0]  REG_DATA         = 8'h08;
  localparam logic [7:0]  REG_STORE        = 8'h0C;
  localparam logic [7:0]  REG_STATUS       = 8'h10;
  localparam logic [7:0]  REG_BUF_READ     = 8'h14;
  localparam logic [7:0]  REG_RESET_VEC    = 8'h18;
  // Control field positions
  localparam int          BIT_ENABLE       = 0;
  localparam int          BIT_ERASE        = 1;
  localparam int          BIT_WRITE        = 2;
  localparam int          BIT_LOCK         = 3;
  localparam int          BIT_REENABLE     = 4;
  localparam int          BIT_BUSY         = 6;
  localparam int          BIT_IRQ_EN       = 7;
  localparam logic [6:0]  CMD_MASK         = 7'h7F;
  localparam logic [6:0]  CMD_LOAD         = 7'h01;
  localparam logic [6:0]  CMD_ERASE        = 7'h03;
  localparam logic [6:0]  CMD_WRITE        = 7'h05;
  localparam logic [6:0]  CMD_LOCK         = 7'h09;
  localparam logic [6:0]  CMD_REENABLE     = 7'h11;
  localparam logic [5:0]  LOCK_FIELD_MASK  = 6'h3F;
  typedef enum logic [1:0] {FSPS_IDLE, FSPS_ARMED, FSPS_BUSY} fsps_state_t;
  typedef enum logic [1:0] {FSPS_OP_ERASE, FSPS_OP_WRITE, FSPS_OP_LOCK} fsps_op_t;
endpackage : fsps_pkg

// File: fsps_rc_timer.sv
`timescale 1ns/1ps
// Operation timer paced by a divided internal oscillator tick
module fsps_rc_timer #(
  parameter int DIV   = fsps_pkg::RC_DIV,
  parameter int TICKS = fsps_pkg::RC_TICKS_MIN
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);
  logic [15:0] div_q;
  logic [15:0] tick_q;
  logic        busy_q;
  logic        done_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || !busy_q || div_q == 16'(DIV - 1))
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  // Counts whole ticks so the time never falls under the minimum
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      busy_q <= 1'b0;
      tick_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (i_start && !busy_q)
      begin
        busy_q <= 1'b1;
        tick_q <= 16'h0000;
      end
      else if (busy_q && div_q == 16'(DIV - 1))
      begin
        if (tick_q == 16'(TICKS - 1))
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          tick_q <= tick_q + 16'h0001;
      end
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
endmodule : fsps_rc_timer

// File: fsps_page_buffer.sv
`timescale 1ns/1ps
// Temporary page buffer with per-word loaded flags
module fsps_page_buffer #(
  parameter int WORDS = fsps_pkg::PAGE_WORDS,
  parameter int AW    = fsps_pkg::WORD_BITS
) (
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  input  wire logic          i_clear,
  input  wire logic          i_load,
  input  wire logic [AW-1:0] i_load_addr,
  input  wire logic [15:0]   i_load_data,
  input  wire logic [AW-1:0] i_read_addr,
  output logic      [15:0]   o_read_data,
  output logic               o_any_loaded
);
  logic [15:0]      mem_q [WORDS];
  logic [WORDS-1:0] valid_q;
  logic [15:0]      rd_q;

  always_ff @(posedge i_clk)
  begin
    if (i_load)
      mem_q[i_load_addr] <= i_load_data;
  end

  // Unloaded words read as erased flash
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || i_clear)
      valid_q <= '0;
    else if (i_load)
      valid_q[i_load_addr] <= 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      rd_q <= 16'hFFFF;
    else
      rd_q <= valid_q[i_read_addr] ? mem_q[i_read_addr] : 16'hFFFF;
  end

  assign o_read_data  = rd_q;
  assign o_any_loaded = |valid_q;
endmodule : fsps_page_buffer

// File: fsps_sequencer.sv
`timescale 1ns/1ps
// Flash self-program sequencer with Wishbone register access
module fsps_sequencer #(
  parameter int RC_DIV = fsps_pkg::RC_DIV,
  parameter int TICKS  = fsps_pkg::RC_TICKS_MIN
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_boot_vector_select_fuse,
  input  wire logic        i_eeprom_write_busy_flag,
  input  wire logic [15:0] i_fetch_addr,
  output logic      [15:0] o_reset_vector,
  output logic             o_rww_read_blocked,
  output logic             o_rww_fetch_fault,
  output logic             o_cpu_halt,
  output logic             o_spm_irq,
  output logic      [7:0]  o_lock_bits,
  output logic             o_flash_erase_stb,
  output logic             o_flash_write_stb,
  output logic      [15:0] o_flash_page_addr
);
  fsps_pkg::fsps_state_t state_q;
  fsps_pkg::fsps_op_t    op_q;
  logic [6:0]  cmd_q;
  logic        irq_en_q;
  logic        busy_flag_q;
  logic [1:0]  arm_cnt_q;
  logic [15:0] pointer_q;
  logic [15:0] data_q;
  logic [15:0] op_addr_q;
  logic        halt_q;
  logic [7:0]  lock_q;
  logic [15:0] reset_vec_q;
  logic        fuse_s1_q;
  logic        fuse_s2_q;
  logic        ee_s1_q;
  logic        ee_s2_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        erase_stb_q;
  logic        write_stb_q;
  logic        timer_busy;
  logic        timer_done;
  logic [15:0] buf_word;
  logic        buf_any;
  logic        wb_req;
  logic        wr_ctrl;
  logic        store;
  logic        do_load;
  logic        do_start;
  logic        buf_clear;

  function automatic logic in_rww(input logic [15:0] a);
    in_rww = a < fsps_pkg::RWW_LIMIT;
  endfunction : in_rww

  function automatic logic [5:0] word_of(input logic [15:0] a);
    word_of = a[fsps_pkg::WORD_BITS:1];
  endfunction : word_of

  // Fuse and EEPROM busy pins pass two flops before any use
  always_ff @(posedge i_clk)
  begin
    fuse_s1_q <= i_boot_vector_select_fuse;
    fuse_s2_q <= fuse_s1_q;
    ee_s1_q   <= i_eeprom_write_busy_flag;
    ee_s2_q   <= ee_s1_q;
  end

  // Fuse is an input only; no register writes it
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      reset_vec_q <= fsps_pkg::APP_RESET_ADDR;
    else
      reset_vec_q <= fuse_s2_q ? fsps_pkg::APP_RESET_ADDR : fsps_pkg::BOOT_RESET_ADDR;
  end

  assign wb_req  = i_wb_cyc && i_wb_stb && !ack_q;
  assign wr_ctrl = wb_req && i_wb_we && i_wb_sel[0] && i_wb_adr == fsps_pkg::REG_CTRL;
  assign store   = wb_req && i_wb_we && i_wb_adr == fsps_pkg::REG_STORE;
  assign do_load  = store && state_q == fsps_pkg::FSPS_ARMED && cmd_q == fsps_pkg::CMD_LOAD;
  assign do_start = store && state_q == fsps_pkg::FSPS_ARMED &&
                    (cmd_q == fsps_pkg::CMD_ERASE || cmd_q == fsps_pkg::CMD_WRITE ||
                     cmd_q == fsps_pkg::CMD_LOCK);
  // Clear on write done, reenable, or EEPROM write mid-load
  assign buf_clear = (timer_done && op_q == fsps_pkg::FSPS_OP_WRITE) ||
                     (store && state_q == fsps_pkg::FSPS_ARMED && cmd_q == fsps_pkg::CMD_REENABLE) ||
                     (ee_s2_q && buf_any);

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      state_q   <= fsps_pkg::FSPS_IDLE;
      cmd_q     <= 7'h00;
      arm_cnt_q <= 2'h0;
      op_q      <= fsps_pkg::FSPS_OP_ERASE;
    end
    else
    begin
      case (state_q)
        fsps_pkg::FSPS_IDLE:
        begin
          // Arming rejected while EEPROM busy; irq_en_q still written
          if (wr_ctrl && !ee_s2_q && i_wb_dat[fsps_pkg::BIT_ENABLE])
          begin
            state_q   <= fsps_pkg::FSPS_ARMED;
            cmd_q     <= i_wb_dat[6:0] & fsps_pkg::CMD_MASK;
            arm_cnt_q <= 2'h0;
          end
        end
        fsps_pkg::FSPS_ARMED:
        begin
          if (do_start)
          begin
            state_q <= fsps_pkg::FSPS_BUSY;
            op_q    <= cmd_q == fsps_pkg::CMD_ERASE ? fsps_pkg::FSPS_OP_ERASE :
                       cmd_q == fsps_pkg::CMD_WRITE ? fsps_pkg::FSPS_OP_WRITE : fsps_pkg::FSPS_OP_LOCK;
          end
          else if (store || arm_cnt_q == 2'(fsps_pkg::ARM_WINDOW - 1))
          begin
            state_q <= fsps_pkg::FSPS_IDLE;
            cmd_q   <= 7'h00;
          end
          else
            arm_cnt_q <= arm_cnt_q + 2'h1;
        end
        fsps_pkg::FSPS_BUSY:
        begin
          if (timer_done)
          begin
            state_q <= fsps_pkg::FSPS_IDLE;
            cmd_q   <= 7'h00;
          end
        end
        default:
          state_q <= fsps_pkg::FSPS_IDLE;
      endcase
    end
  end

  // Address captured at start; later pointer writes have no effect
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      op_addr_q <= 16'h0000;
    else if (do_start && cmd_q != fsps_pkg::CMD_LOCK)
      op_addr_q <= {pointer_q[15:fsps_pkg::WORD_BITS + 1], {(fsps_pkg::WORD_BITS + 1){1'b0}}};
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      halt_q <= 1'b0;
    else if (do_start)
      halt_q <= cmd_q != fsps_pkg::CMD_LOCK && !in_rww(pointer_q);
    else if (timer_done)
      halt_q <= 1'b0;
  end

  // Busy set by erase or write only; reenable clears when idle
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      busy_flag_q <= 1'b0;
    else if (do_start && cmd_q != fsps_pkg::CMD_LOCK)
      busy_flag_q <= 1'b1;
    else if (store && state_q == fsps_pkg::FSPS_ARMED && cmd_q == fsps_pkg::CMD_REENABLE)
      busy_flag_q <= 1'b0;
  end

  // Pointer bits ignored for lock set
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      lock_q <= fsps_pkg::LOCK_RESET;
    else if (do_start && cmd_q == fsps_pkg::CMD_LOCK)
      lock_q[5:0] <= lock_q[5:0] & (data_q[5:0] | ~fsps_pkg::LOCK_FIELD_MASK);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      pointer_q <= 16'h0000;
      data_q    <= 16'h0000;
      irq_en_q  <= 1'b0;
    end
    else if (wb_req && i_wb_we)
    begin
      if (i_wb_adr == fsps_pkg::REG_POINTER)
        pointer_q <= i_wb_dat[15:0];
      else if (i_wb_adr == fsps_pkg::REG_DATA)
        data_q <= i_wb_dat[15:0];
      else if (i_wb_adr == fsps_pkg::REG_CTRL && i_wb_sel[0])
        irq_en_q <= i_wb_dat[fsps_pkg::BIT_IRQ_EN];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      erase_stb_q <= 1'b0;
      write_stb_q <= 1'b0;
    end
    else
    begin
      erase_stb_q <= timer_done && op_q == fsps_pkg::FSPS_OP_ERASE;
      write_stb_q <= timer_done && op_q == fsps_pkg::FSPS_OP_WRITE;
    end
  end

  // One-cycle ack; unmapped reads return zero
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ack_q  <= wb_req;
      rdat_q <= 32'h00000000;
      if (wb_req && !i_wb_we)
      begin
        if (i_wb_adr == fsps_pkg::REG_CTRL)
          rdat_q <= {24'h000000, irq_en_q, busy_flag_q, 6'h00} |
                    {25'h0000000, cmd_q & {7{state_q != fsps_pkg::FSPS_IDLE}}};
        else if (i_wb_adr == fsps_pkg::REG_POINTER)
          rdat_q <= {16'h0000, pointer_q};
        else if (i_wb_adr == fsps_pkg::REG_DATA)
          rdat_q <= {16'h0000, data_q};
        else if (i_wb_adr == fsps_pkg::REG_STATUS)
          rdat_q <= {24'h000000, lock_q};
        else if (i_wb_adr == fsps_pkg::REG_BUF_READ)
          rdat_q <= {24'h000000, pointer_q[0] ? buf_word[15:8] : buf_word[7:0]};
        else if (i_wb_adr == fsps_pkg::REG_RESET_VEC)
          rdat_q <= {16'h0000, reset_vec_q};
      end
    end
  end

  fsps_rc_timer #(
    .DIV   (RC_DIV),
    .TICKS (TICKS)
  ) u_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_start   (do_start),
    .o_busy    (timer_busy),
    .o_done    (timer_done)
  );

  // Random word order accepted
  fsps_page_buffer u_buf (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_clear      (buf_clear),
    .i_load       (do_load),
    .i_load_addr  (word_of(pointer_q)),
    .i_load_data  (data_q),
    .i_read_addr  (word_of(pointer_q)),
    .o_read_data  (buf_word),
    .o_any_loaded (buf_any)
  );

  assign o_wb_dat           = rdat_q;
  assign o_wb_ack           = ack_q;
  assign o_reset_vector     = reset_vec_q;
  assign o_rww_read_blocked = busy_flag_q;
  assign o_rww_fetch_fault  = busy_flag_q && in_rww(i_fetch_addr);
  assign o_cpu_halt         = halt_q && timer_busy;
  assign o_spm_irq          = irq_en_q && state_q == fsps_pkg::FSPS_IDLE;
  assign o_lock_bits        = lock_q;
  assign o_flash_erase_stb  = erase_stb_q;
  assign o_flash_write_stb  = write_stb_q;
  assign o_flash_page_addr  = op_addr_q;
endmodule : fsps_sequencer

// File: fsps_sequencer_checker.sv
// Port assertions for the flash self-program sequencer
`timescale 1ns/1ps
module fsps_sequencer_checker (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        o_wb_ack,
  input wire logic [15:0] i_fetch_addr,
  input wire logic        o_rww_read_blocked,
  input wire logic        o_rww_fetch_fault,
  input wire logic        o_cpu_halt,
  input wire logic        o_spm_irq,
  input wire logic [7:0]  o_lock_bits,
  input wire logic        o_flash_erase_stb,
  input wire logic        o_flash_write_stb,
  input wire logic [15:0] o_flash_page_addr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_taken;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_answer;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  sequence s_op_end;
    o_flash_erase_stb || o_flash_write_stb;
  endsequence
  property p_ack;
    s_taken |=> s_answer;
  endproperty
  property p_fault;
    o_rww_fetch_fault == (o_rww_read_blocked && (i_fetch_addr < 16'h3800));
  endproperty
  property p_halt;
    o_cpu_halt |-> o_rww_read_blocked && !o_spm_irq && (o_flash_page_addr >= 16'h3800);
  endproperty
  property p_latch;
    o_cpu_halt |=> $stable(o_flash_page_addr);
  endproperty
  property p_align;
    s_op_end |-> o_flash_page_addr[6:0] == 7'h00;
  endproperty
  property p_pulse;
    s_op_end |=> !(o_flash_erase_stb || o_flash_write_stb);
  endproperty
  property p_excl;
    !(o_flash_erase_stb && o_flash_write_stb);
  endproperty
  property p_lock;
    (o_lock_bits & ~$past(o_lock_bits)) == 8'h00;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle after request");
  a_fault: assert property (p_fault) else $error("fetch fault wrong");
  a_halt: assert property (p_halt) else $error("halt without busy or with irq");
  a_latch: assert property (p_latch) else $error("page address moved during op");
  a_align: assert property (p_align) else $error("page address not page aligned");
  a_pulse: assert property (p_pulse) else $error("flash strobe longer than a cycle");
  a_excl: assert property (p_excl) else $error("erase and write strobes together");
  a_lock: assert property (p_lock) else $error("lock bit returned to one");
endmodule : fsps_sequencer_checker

bind fsps_sequencer fsps_sequencer_checker u_chk (.i_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack,
  .i_fetch_addr, .o_rww_read_blocked, .o_rww_fetch_fault, .o_cpu_halt, .o_spm_irq, .o_lock_bits,
  .o_flash_erase_stb, .o_flash_write_stb, .o_flash_page_addr);

// File: fsps_cpu_model.sv
// Processor-side bus model issuing register and store requests
`timescale 1ns/1ps
module fsps_cpu_model (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdat,
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic      [7:0]  o_adr,
  output logic      [31:0] o_dat
);
  initial
  begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'h00;
    o_dat = 32'h0;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= w;
    o_adr <= a;
    o_dat <= d;
    do @(posedge i_clk);
    while (i_ack !== 1'b1);
    q = i_rdat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    // Released data never keeps its old value
    o_dat <= ~d;
  endtask : bus
  // Store is the very next request, inside the arming window
  task automatic cmd(input logic [6:0] c, input logic ie);
    logic [31:0] q;
    bus(1'b1, 8'h00, {24'h0, ie, c}, q);
    bus(1'b1, 8'h0C, 32'h0, q);
  endtask : cmd
endmodule : fsps_cpu_model

// File: test_flash_self_program_sequencer.sv
// Self-checking testbench for the flash self-program sequencer
`timescale 1ns/1ps
module test_flash_self_program_sequencer;
  typedef struct packed {logic [31:0] exp; logic [31:0] mask;} fsps_note_t;
  logic        clk;
  logic        reset_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        fuse;
  logic        ee_busy;
  logic [15:0] fetch;
  logic [15:0] rvec;
  logic        blocked;
  logic        fault;
  logic        halt;
  logic        irq;
  logic [7:0]  lock;
  logic        er_stb;
  logic        wr_stb;
  logic [15:0] page;
  logic [31:0] rv;
  logic [15:0] seed;
  logic [15:0] wd [4];
  logic [5:0]  wl [4] = '{6'h05, 6'h01, 6'h3F, 6'h00};
  fsps_note_t  notes [$];
  fsps_note_t  nt;
  int          errors = 0;
  int          check_count = 0;
  int          n;

  fsps_sequencer #(.RC_DIV(2), .TICKS(8)) DUT (.i_clk(clk), .i_reset_n(reset_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_boot_vector_select_fuse(fuse), .i_eeprom_write_busy_flag(ee_busy),
    .i_fetch_addr(fetch), .o_reset_vector(rvec), .o_rww_read_blocked(blocked), .o_rww_fetch_fault(fault),
    .o_cpu_halt(halt), .o_spm_irq(irq), .o_lock_bits(lock), .o_flash_erase_stb(er_stb),
    .o_flash_write_stb(wr_stb), .o_flash_page_addr(page));
  fsps_cpu_model cpu (.i_clk(clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(we),
    .o_adr(adr), .o_dat(wdat));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done();
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e & m, m});
    cpu.bus(1'b0, a, 32'h0, rv);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    cpu.bus(1'b1, a, d, x);
  endtask : wr
  task automatic ptr(input logic [5:0] k, input logic b);
    wr(8'h04, {16'h0, 9'h001, k, b});
  endtask : ptr
  task automatic ld(input logic [5:0] k, input logic [15:0] d);
    ptr(k, 1'b0);
    wr(8'h08, {16'h0, d});
    cpu.cmd(7'h01, 1'b0);
  endtask : ld
  // Both byte lanes of one buffer word
  task automatic bufchk(input logic [5:0] k, input logic [15:0] e);
    ptr(k, 1'b0);
    rd(8'h14, {24'h0, e[7:0]}, 32'hFF);
    ptr(k, 1'b1);
    rd(8'h14, {24'h0, e[15:8]}, 32'hFF);
  endtask : bufchk
  task automatic wait_op(input logic [15:0] e);
    int k;
    k = 0;
    while (!(er_stb === 1'b1 || wr_stb === 1'b1) && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    check("op end", {31'h0, er_stb | wr_stb}, 32'h1);
    check("page address", {16'h0, page}, {16'h0, e});
  endtask : wait_op

  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      check("read data", rdat & nt.mask, nt.exp);
    end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end

  initial
  begin
    reset_n = 1'b0;
    fuse    = 1'b0;
    ee_busy = 1'b0;
    fetch   = 16'h0100;
    seed    = 16'hD3DA;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("reset vector", {16'h0, rvec}, 32'h3800);
    rd(8'h18, 32'h3800, 32'hFFFF);
    wr(8'h18, 32'h0);
    rd(8'h18, 32'h3800, 32'hFFFF);
    rd(8'h10, 32'hFF, 32'hFF);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      wd[i] = seed;
      ld(wl[i], seed);
    end
    for (int i = 0; i < 4; i++)
      bufchk(wl[i], wd[i]);
    wr(8'h04, 32'h00BE);
    seed = lfsr(seed);
    wr(8'h08, {16'h0, seed});
    cpu.cmd(7'h03, 1'b1);
    rd(8'h00, 32'h41, 32'h41);
    check("fetch fault", {31'h0, fault}, 32'h1);
    check("halt", {31'h0, halt}, 32'h0);
    wr(8'h04, 32'h1234);
    wait_op(16'h0080);
    @(posedge clk);
    check("busy held", {31'h0, blocked}, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    bufchk(wl[0], wd[0]);
    wr(8'h04, 32'h0080);
    cpu.cmd(7'h05, 1'b1);
    wait_op(16'h0080);
    bufchk(wl[0], 16'hFFFF);
    wr(8'h04, 32'h3800);
    cpu.cmd(7'h03, 1'b0);
    @(posedge clk);
    check("halt", {31'h0, halt}, 32'h1);
    wait_op(16'h3800);
    ld(6'h03, 16'hA5C3);
    cpu.cmd(7'h11, 1'b0);
    rd(8'h00, 32'h0, 32'h40);
    bufchk(6'h03, 16'hFFFF);
    ptr(6'h07, 1'b0);
    wr(8'h08, 32'hBEEF);
    wr(8'h00, 32'h01);
    repeat (6) @(posedge clk);
    rd(8'h00, 32'h0, 32'h7F);
    wr(8'h0C, 32'h0);
    bufchk(6'h07, 16'hFFFF);
    seed = lfsr(seed);
    wr(8'h04, {16'h0, seed});
    wr(8'h08, 32'hC2);
    cpu.cmd(7'h09, 1'b0);
    check("lock busy", {30'h0, blocked, halt}, 32'h0);
    n = 0;
    do
    begin
      rd(8'h00, 32'h0, 32'h0);
      n++;
    end
    while (rv[0] !== 1'b0 && n < 30);
    check("enable clear", {31'h0, rv[0]}, 32'h0);
    rd(8'h10, 32'hC2, 32'hFF);
    check("lock pins", {24'h0, lock}, 32'hC2);
    ld(6'h09, 16'h5A3C);
    ee_busy <= 1'b1;
    repeat (5) @(posedge clk);
    ee_busy <= 1'b0;
    repeat (4) @(posedge clk);
    bufchk(6'h09, 16'hFFFF);
    ee_busy <= 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h04, 32'h0080);
    cpu.cmd(7'h03, 1'b0);
    repeat (3) @(posedge clk);
    check("refused erase", {31'h0, blocked}, 32'h0);
    ee_busy <= 1'b0;
    // Let the busy flag clear through the pin sync before touching control
    repeat (3) @(posedge clk);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge clk);
    check("irq off", {31'h0, irq}, 32'h0);
    test_done();
  end
endmodule : test_flash_self_program_sequencer
